// file: hw/rxf_defs.svh
/*
 * Named offsets, frame constants, register map and reset values of the
 * receive packet framer. Definitions only; included by bare name.
 */
`ifndef RXF_DEFS_SVH
`define RXF_DEFS_SVH

// ****************************************
// Frame layout
// ****************************************
`define RXF_DELIM 8'h7E
`define RXF_TYPE_STD 8'h90
`define RXF_TYPE_EXP 8'h91
`define RXF_CSUM_BASE 8'hFF
`define RXF_OPT_MASK 8'h63
`define RXF_LEN_STD 16'h000C
`define RXF_LEN_EXP 16'h0012
`define RXF_OFF_DELIM 5'h00
`define RXF_OFF_LEN_HI 5'h01
`define RXF_OFF_LEN_LO 5'h02
`define RXF_OFF_TYPE 5'h03
`define RXF_OFF_SRC64_MSB 5'h04
`define RXF_OFF_SRC64_LSB 5'h0B
`define RXF_OFF_SRC16_HI 5'h0C
`define RXF_OFF_SRC16_LO 5'h0D
`define RXF_OFF_OPT_STD 5'h0E
`define RXF_OFF_SRC_EP 5'h0E
`define RXF_OFF_DST_EP 5'h0F
`define RXF_OFF_CLUS_HI 5'h10
`define RXF_OFF_CLUS_LO 5'h11
`define RXF_OFF_PROF_HI 5'h12
`define RXF_OFF_PROF_LO 5'h13
`define RXF_OFF_OPT_EXP 5'h14

// ****************************************
// Register map and reset values
// ****************************************
`define RXF_REG_CTRL 8'h00
`define RXF_REG_EP 8'h04
`define RXF_REG_CLUS 8'h08
`define RXF_REG_STAT 8'h0C
`define RXF_RESP_OKAY 2'h0
`define RXF_RESP_SLVERR 2'h2
`define RXF_RST_SRC_EP 8'h01
`define RXF_RST_DST_EP 8'h01
`define RXF_RST_CLUS 16'h0000

`endif

// file: hw/rxf_pkg.sv
/*
 * Types of the receive packet framer: packet metadata carrier, machine
 * states and the complete state record. Assumes rxf_defs.svh for numbers.
 */
package rxf_pkg;

	// ****************************************
	// Metadata delivered with each packet
	// ****************************************
	typedef struct packed {
		logic [63:0] src64;
		logic [15:0] src16;
		logic [7:0] opts;
		logic [7:0] src_ep;
		logic [7:0] dst_ep;
		logic [15:0] cluster;
		logic [15:0] profile;
		logic plain_req;
		logic [15:0] plen;
	} rx_meta_t;

	typedef enum logic [1:0] {IDLE, HEAD, BODY, SUM} fsm_t;

	// ****************************************
	// Whole module state
	// ****************************************
	typedef struct packed {
		fsm_t fsm;
		rx_meta_t meta;
		logic fmt;
		logic [4:0] idx;
		logic [15:0] cnt;
		logic [7:0] sum;
		logic [7:0] odata;
		logic ovalid;
		logic is_sum;
		logic [16:0] opos;
		logic fmt_sel;
		logic [7:0] loc_sep;
		logic [7:0] loc_dep;
		logic [15:0] loc_clus;
		logic [15:0] frames;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} rxf_state_t;

endpackage

// file: hw/rx_packet_api_framer.sv
/*
 * Receive packet framer: turns one received RF packet (metadata word plus
 * payload byte stream) into a serial API frame, standard or explicit form,
 * with settings reached over AXI4-Lite.
 * Assumes the radio path gives an exact payload length with the metadata
 * and offers the payload bytes only after the metadata was taken.
 */
// Operation
// RULE_01: Format 0 emits frame type 0x90.
// RULE_02: Standard: 64-bit source, MSB first, offsets 4-11.
// RULE_03: 16-bit source address at 12 and 13.
// RULE_04: Options byte flags: acked, broadcast, encrypted.
// RULE_05: Options byte also passes the 0x40 flag.
// RULE_06: Standard payload copied in order from 15.
// RULE_07: Format 1 emits explicit frame type 0x91.
// RULE_08: Explicit: 64-bit then 16-bit source addresses.
// RULE_09: Explicit: source endpoint 14, destination endpoint 15.
// RULE_10: Explicit: cluster identifier at offsets 16-17.
// RULE_11: Explicit: profile 18-19, options 20, payload 21.
// RULE_12: Plain requests report local endpoints and cluster.
// RULE_13: Frame starts 0x7E, then big-endian length.
// RULE_14: Trailing checksum is 0xFF minus byte sum.
`timescale 1ns/10ps
`include "rxf_defs.svh"

module rx_packet_api_framer (
	// Clock and reset
	input wire logic CLOCK_IN,
	input wire logic SRST_IN,
	// Packet metadata from the receive path
	input wire logic META_VALID_IN,
	input wire rxf_pkg::rx_meta_t META_IN,
	output logic META_READY_OUT,
	// Payload bytes from the receive path
	input wire logic PAY_VALID_IN,
	input wire logic [7:0] PAY_DATA_IN,
	output logic PAY_READY_OUT,
	// Serial API byte stream to the host
	output logic SER_VALID_OUT,
	output logic [7:0] SER_DATA_OUT,
	input wire logic SER_READY_IN,
	// AXI4-Lite write channels
	input wire logic AXI_AWVALID_IN,
	output logic AXI_AWREADY_OUT,
	input wire logic [7:0] AXI_AWADDR_IN,
	input wire logic AXI_WVALID_IN,
	output logic AXI_WREADY_OUT,
	input wire logic [31:0] AXI_WDATA_IN,
	input wire logic [3:0] AXI_WSTRB_IN,
	output logic AXI_BVALID_OUT,
	input wire logic AXI_BREADY_IN,
	output logic [1:0] AXI_BRESP_OUT,
	// AXI4-Lite read channels
	input wire logic AXI_ARVALID_IN,
	output logic AXI_ARREADY_OUT,
	input wire logic [7:0] AXI_ARADDR_IN,
	output logic AXI_RVALID_OUT,
	input wire logic AXI_RREADY_IN,
	output logic [31:0] AXI_RDATA_OUT,
	output logic [1:0] AXI_RRESP_OUT
);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [7:0] hdr_byte(input logic [4:0] idx, input rxf_pkg::rx_meta_t m,
		input logic fmt, input logic [15:0] len, input logic [7:0] sep,
		input logic [7:0] dep, input logic [15:0] clus);
		logic [7:0] b;
		b = 8'h00;
		if (idx >= `RXF_OFF_SRC64_MSB && idx <= `RXF_OFF_SRC64_LSB) begin
			b = 8'(m.src64 >> {(`RXF_OFF_SRC64_LSB - idx), 3'b000}); // RULE_02 RULE_08
		end else begin
			case (idx)
				`RXF_OFF_DELIM: b = `RXF_DELIM; // RULE_13
				`RXF_OFF_LEN_HI: b = len[15:8]; // RULE_13
				`RXF_OFF_LEN_LO: b = len[7:0];
				`RXF_OFF_TYPE: b = fmt ? `RXF_TYPE_EXP : `RXF_TYPE_STD; // RULE_01 RULE_07
				`RXF_OFF_SRC16_HI: b = m.src16[15:8]; // RULE_03
				`RXF_OFF_SRC16_LO: b = m.src16[7:0]; // RULE_03
				`RXF_OFF_SRC_EP: b = fmt ? sep : (m.opts & `RXF_OPT_MASK); // RULE_04 RULE_05 RULE_09
				`RXF_OFF_DST_EP: b = dep; // RULE_09
				`RXF_OFF_CLUS_HI: b = clus[15:8]; // RULE_10
				`RXF_OFF_CLUS_LO: b = clus[7:0]; // RULE_10
				`RXF_OFF_PROF_HI: b = m.profile[15:8]; // RULE_11
				`RXF_OFF_PROF_LO: b = m.profile[7:0]; // RULE_11
				`RXF_OFF_OPT_EXP: b = m.opts & `RXF_OPT_MASK; // RULE_11 RULE_04 RULE_05
				default: b = 8'h00;
			endcase
		end
		return b;
	endfunction

	// ****************************************
	// State and derived terms
	// ****************************************
	rxf_pkg::rxf_state_t s_q;
	rxf_pkg::rxf_state_t s_d;
	logic load;
	logic [4:0] last_idx;
	logic [15:0] frame_len;
	logic [7:0] sep;
	logic [7:0] dep;
	logic [15:0] clus;
	logic [7:0] hdr;
	logic aw_hs;
	logic w_hs;
	logic do_write;
	logic [7:0] wa;
	logic [31:0] wd;
	logic [3:0] ws;
	logic [31:0] ep_word;
	logic [31:0] clus_word;
	logic [31:0] ctrl_new;
	logic [31:0] ep_new;
	logic [31:0] clus_new;
	logic busy;

	// Next byte may enter the output register only once the old one is gone
	assign load = !s_q.ovalid || SER_READY_IN;
	assign last_idx = s_q.fmt ? `RXF_OFF_OPT_EXP : `RXF_OFF_OPT_STD;
	assign frame_len = s_q.meta.plen + (s_q.fmt ? `RXF_LEN_EXP : `RXF_LEN_STD); // RULE_13
	assign sep = s_q.meta.plain_req ? s_q.loc_sep : s_q.meta.src_ep; // RULE_12
	assign dep = s_q.meta.plain_req ? s_q.loc_dep : s_q.meta.dst_ep; // RULE_12
	assign clus = s_q.meta.plain_req ? s_q.loc_clus : s_q.meta.cluster; // RULE_12
	assign hdr = hdr_byte(s_q.idx, s_q.meta, s_q.fmt, frame_len, sep, dep, clus);
	assign aw_hs = AXI_AWVALID_IN && AXI_AWREADY_OUT;
	assign w_hs = AXI_WVALID_IN && AXI_WREADY_OUT;
	assign do_write = (s_q.aw_got || aw_hs) && (s_q.w_got || w_hs);
	assign wa = s_q.aw_got ? s_q.awaddr : AXI_AWADDR_IN;
	assign wd = s_q.w_got ? s_q.wdata : AXI_WDATA_IN;
	assign ws = s_q.w_got ? s_q.wstrb : AXI_WSTRB_IN;
	assign ep_word = {16'h0000, s_q.loc_dep, s_q.loc_sep};
	assign clus_word = {16'h0000, s_q.loc_clus};
	assign ctrl_new = merge({31'h00000000, s_q.fmt_sel}, wd, ws);
	assign ep_new = merge(ep_word, wd, ws);
	assign clus_new = merge(clus_word, wd, ws);
	assign busy = (s_q.fsm != rxf_pkg::IDLE) || s_q.ovalid;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_d = s_q;
		s_d.is_sum = s_q.is_sum && !load;
		case (s_q.fsm)
			rxf_pkg::IDLE: begin
				if (load) begin
					s_d.ovalid = 1'b0;
				end
				// Format is frozen per frame so a control register write cannot split one
				if (META_VALID_IN && load) begin
					s_d.meta = META_IN;
					s_d.fmt = s_q.fmt_sel; // RULE_01 RULE_07
					s_d.idx = `RXF_OFF_DELIM;
					s_d.sum = 8'h00;
					s_d.fsm = rxf_pkg::HEAD;
				end
			end
			rxf_pkg::HEAD: begin
				if (load) begin
					s_d.odata = hdr;
					s_d.ovalid = 1'b1;
					s_d.opos = {12'h000, s_q.idx};
					if (s_q.idx >= `RXF_OFF_TYPE) begin
						s_d.sum = s_q.sum + hdr; // RULE_14
					end
					s_d.idx = s_q.idx + 5'h01;
					if (s_q.idx == last_idx) begin
						s_d.cnt = s_q.meta.plen;
						s_d.fsm = (s_q.meta.plen == 16'h0000) ? rxf_pkg::SUM : rxf_pkg::BODY;
					end
				end
			end
			rxf_pkg::BODY: begin
				if (load) begin
					s_d.ovalid = PAY_VALID_IN;
					if (PAY_VALID_IN) begin
						s_d.odata = PAY_DATA_IN; // RULE_06 RULE_11
						s_d.opos = s_q.opos + 17'h00001;
						s_d.sum = s_q.sum + PAY_DATA_IN; // RULE_14
						s_d.cnt = s_q.cnt - 16'h0001;
						if (s_q.cnt == 16'h0001) begin
							s_d.fsm = rxf_pkg::SUM;
						end
					end
				end
			end
			rxf_pkg::SUM: begin
				if (load) begin
					s_d.odata = `RXF_CSUM_BASE - s_q.sum; // RULE_14
					s_d.ovalid = 1'b1;
					s_d.is_sum = 1'b1;
					s_d.opos = s_q.opos + 17'h00001;
					s_d.frames = s_q.frames + 16'h0001;
					s_d.fsm = rxf_pkg::IDLE;
				end
			end
			default: begin
				s_d.fsm = rxf_pkg::IDLE;
			end
		endcase

		// Register writes; address and data may come in either order
		if (aw_hs) begin
			s_d.aw_got = 1'b1;
			s_d.awaddr = AXI_AWADDR_IN;
		end
		if (w_hs) begin
			s_d.w_got = 1'b1;
			s_d.wdata = AXI_WDATA_IN;
			s_d.wstrb = AXI_WSTRB_IN;
		end
		if (s_q.bvalid && AXI_BREADY_IN) begin
			s_d.bvalid = 1'b0;
		end
		if (do_write) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = `RXF_RESP_OKAY;
			case (wa)
				`RXF_REG_CTRL: s_d.fmt_sel = ctrl_new[0];
				`RXF_REG_EP: begin
					s_d.loc_sep = ep_new[7:0];
					s_d.loc_dep = ep_new[15:8];
				end
				`RXF_REG_CLUS: s_d.loc_clus = clus_new[15:0];
				`RXF_REG_STAT: s_d.bresp = `RXF_RESP_OKAY;
				default: s_d.bresp = `RXF_RESP_SLVERR;
			endcase
		end

		// Register reads
		if (s_q.rvalid && AXI_RREADY_IN) begin
			s_d.rvalid = 1'b0;
		end
		if (AXI_ARVALID_IN && AXI_ARREADY_OUT) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = `RXF_RESP_OKAY;
			case (AXI_ARADDR_IN)
				`RXF_REG_CTRL: s_d.rdata = {31'h00000000, s_q.fmt_sel};
				`RXF_REG_EP: s_d.rdata = ep_word;
				`RXF_REG_CLUS: s_d.rdata = clus_word;
				`RXF_REG_STAT: s_d.rdata = {s_q.frames, 15'h0000, busy};
				default: begin
					s_d.rdata = 32'h00000000;
					s_d.rresp = `RXF_RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK_IN) begin
		if (SRST_IN) begin
			s_q <= '0;
			s_q.fsm <= rxf_pkg::IDLE;
			s_q.loc_sep <= `RXF_RST_SRC_EP;
			s_q.loc_dep <= `RXF_RST_DST_EP;
			s_q.loc_clus <= `RXF_RST_CLUS;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// New metadata waits until the old checksum byte leaves, so it stays tied to its frame
	assign META_READY_OUT = (s_q.fsm == rxf_pkg::IDLE) && load;
	assign PAY_READY_OUT = (s_q.fsm == rxf_pkg::BODY) && load;
	assign SER_VALID_OUT = s_q.ovalid;
	assign SER_DATA_OUT = s_q.odata;
	assign AXI_AWREADY_OUT = !s_q.aw_got && !s_q.bvalid;
	assign AXI_WREADY_OUT = !s_q.w_got && !s_q.bvalid;
	assign AXI_BVALID_OUT = s_q.bvalid;
	assign AXI_BRESP_OUT = s_q.bresp;
	assign AXI_ARREADY_OUT = !s_q.rvalid;
	assign AXI_RVALID_OUT = s_q.rvalid;
	assign AXI_RDATA_OUT = s_q.rdata;
	assign AXI_RRESP_OUT = s_q.rresp;

	// ****************************************
	// Checks
	// ****************************************
	// Independent running sum of what the host really accepted
	logic [7:0] ref_sum_q;
	always_ff @(posedge CLOCK_IN) begin
		if (SRST_IN) begin
			ref_sum_q <= 8'h00;
		end else if (SER_VALID_OUT && SER_READY_IN) begin
			if (s_q.opos < {12'h000, `RXF_OFF_TYPE}) begin
				ref_sum_q <= 8'h00;
			end else if (!s_q.is_sum) begin
				ref_sum_q <= ref_sum_q + SER_DATA_OUT;
			end
		end
	end

	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (SRST_IN);

	frame_delim_a: assert property (SER_VALID_OUT && !s_q.is_sum && // RULE_13
		s_q.opos == {12'h000, `RXF_OFF_DELIM} |-> SER_DATA_OUT == `RXF_DELIM)
		else $error("frame does not start with delimiter");
	frame_type_a: assert property (SER_VALID_OUT && !s_q.is_sum && // RULE_01
		s_q.opos == {12'h000, `RXF_OFF_TYPE} |->
		SER_DATA_OUT == (s_q.fmt ? `RXF_TYPE_EXP : `RXF_TYPE_STD))
		else $error("wrong frame type byte");
	src_addr_a: assert property (SER_VALID_OUT && !s_q.is_sum && // RULE_02
		s_q.opos == {12'h000, `RXF_OFF_SRC64_MSB} |-> SER_DATA_OUT == s_q.meta.src64[63:56])
		else $error("64-bit source not MSB first");
	net_addr_a: assert property (SER_VALID_OUT && !s_q.is_sum && // RULE_03
		s_q.opos == {12'h000, `RXF_OFF_SRC16_LO} |-> SER_DATA_OUT == s_q.meta.src16[7:0])
		else $error("16-bit source low byte wrong");
	std_opts_a: assert property (SER_VALID_OUT && !s_q.is_sum && !s_q.fmt && // RULE_05
		s_q.opos == {12'h000, `RXF_OFF_OPT_STD} |-> SER_DATA_OUT == (s_q.meta.opts & `RXF_OPT_MASK))
		else $error("standard options byte wrong");
	local_ep_a: assert property (SER_VALID_OUT && !s_q.is_sum && s_q.fmt && // RULE_12
		s_q.meta.plain_req && s_q.opos == {12'h000, `RXF_OFF_SRC_EP} |->
		SER_DATA_OUT == s_q.loc_sep)
		else $error("plain request must report local endpoint");
	cluster_hi_a: assert property (SER_VALID_OUT && !s_q.is_sum && s_q.fmt && // RULE_10
		s_q.opos == {12'h000, `RXF_OFF_CLUS_HI} |->
		SER_DATA_OUT == (s_q.meta.plain_req ? s_q.loc_clus[15:8] : s_q.meta.cluster[15:8]))
		else $error("cluster high byte wrong");
	payload_copy_a: assert property (PAY_VALID_IN && PAY_READY_OUT |=> // RULE_06
		SER_VALID_OUT && SER_DATA_OUT == $past(PAY_DATA_IN))
		else $error("payload byte not passed on");
	csum_value_a: assert property (SER_VALID_OUT && s_q.is_sum |-> // RULE_14
		SER_DATA_OUT == 8'(`RXF_CSUM_BASE - ref_sum_q) &&
		s_q.opos == {1'b0, frame_len} + {12'h000, `RXF_OFF_TYPE})
		else $error("checksum value or place wrong");
	ser_hold_a: assert property (SER_VALID_OUT && !SER_READY_IN |=>
		SER_VALID_OUT && $stable(SER_DATA_OUT))
		else $error("serial byte changed while stalled");
	bresp_hold_a: assert property (AXI_BVALID_OUT && !AXI_BREADY_IN |=>
		AXI_BVALID_OUT && $stable(AXI_BRESP_OUT))
		else $error("write response dropped");

endmodule // rx_packet_api_framer

// file: test/host_sink.sv
/*
 * Host side model: sink of the serial API byte stream.
 * Assumes the bench picks prompt or stalling behaviour through slow_in.
 */
`timescale 1ns/10ps
module host_sink (
	// Clock and mode
	input wire logic clk_in,
	input wire logic slow_in,
	// Stream handshake
	output logic ready_out
);
	// ****
	// Ready pattern
	// ****
	// Random stalls, when slow_in is set, make the framer hold the waiting byte across each gap
	always @(posedge clk_in) begin
		ready_out <= !slow_in || ($urandom_range(0, 2) != 0);
	end
endmodule // host_sink

// file: test/tb_rx_packet_api_framer.sv
/*
 * Self-checking bench of the receive packet framer.
 * Assumes the design files and host_sink are compiled first.
 */
`timescale 1ns/10ps
module tb_rx_packet_api_framer;
	// ****
	// Signals
	// ****
	logic clk = 1'b0, srst = 1'b1, slow = 1'b0;
	logic meta_v = 1'b0, pay_v = 1'b0, ser_rdy;
	rxf_pkg::rx_meta_t meta = '0, m;
	logic [7:0] pay_d = 8'h00, ser_d, aw_a = 8'h00, ar_a = 8'h00;
	logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
	logic [31:0] w_d = 32'h00000000, r_d, w;
	logic [3:0] w_s = 4'hF;
	logic meta_rdy, pay_rdy, ser_v, aw_rdy, w_rdy, b_v, ar_rdy, r_v;
	logic [1:0] b_resp, r_resp;
	int fail_count = 0, tests_run = 0, nfr = 0;
	logic [7:0] sq[$], pl[$];
	logic [1:0] bq[$];
	logic [33:0] rq[$];
	logic [7:0] lsep = 8'h01, ldep = 8'h01;
	logic [15:0] lclus = 16'h0000;
	logic [159:0] rnd;
	logic [7:0] opt_codes[9] = '{8'h00, 8'h01, 8'h02, 8'h20, 8'h21, 8'h22, 8'h60, 8'h61, 8'h62};

	always #25 clk = ~clk;

	rx_packet_api_framer uut (.CLOCK_IN(clk), .SRST_IN(srst), .META_VALID_IN(meta_v),
		.META_IN(meta), .META_READY_OUT(meta_rdy), .PAY_VALID_IN(pay_v), .PAY_DATA_IN(pay_d),
		.PAY_READY_OUT(pay_rdy), .SER_VALID_OUT(ser_v), .SER_DATA_OUT(ser_d),
		.SER_READY_IN(ser_rdy), .AXI_AWVALID_IN(aw_v), .AXI_AWREADY_OUT(aw_rdy),
		.AXI_AWADDR_IN(aw_a), .AXI_WVALID_IN(w_v), .AXI_WREADY_OUT(w_rdy), .AXI_WDATA_IN(w_d),
		.AXI_WSTRB_IN(w_s), .AXI_BVALID_OUT(b_v), .AXI_BREADY_IN(b_r), .AXI_BRESP_OUT(b_resp),
		.AXI_ARVALID_IN(ar_v), .AXI_ARREADY_OUT(ar_rdy), .AXI_ARADDR_IN(ar_a),
		.AXI_RVALID_OUT(r_v), .AXI_RREADY_IN(r_r), .AXI_RDATA_OUT(r_d), .AXI_RRESP_OUT(r_resp));

	host_sink host (.clk_in(clk), .slow_in(slow), .ready_out(ser_rdy));

	// ****
	// Checking
	// ****
	task automatic chk(input string what, input logic [33:0] e, input logic [33:0] s);
		tests_run++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, e, s);
		end
	endtask

	task automatic stop_test();
		$display("Checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Negedge sampling sees the values that the next rising edge takes
	always @(negedge clk) begin
		if (ser_v && ser_rdy)
			chk("serial byte", sq.size() ? {26'h0, sq.pop_front()} : 'x, {26'h0, ser_d});
		if (b_v && b_r)
			chk("write response", bq.size() ? {32'h0, bq.pop_front()} : 'x, {32'h0, b_resp});
		if (r_v && r_r)
			chk("read response", rq.size() ? rq.pop_front() : 'x, {r_resp, r_d});
	end

	initial begin
		#3000000;
		fail_count++;
		stop_test();
	end

	// ****
	// Drivers
	// ****
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic ta, tw, na, nw;
		bq.push_back(er);
		aw_v <= 1'b1;
		w_v <= 1'b1;
		aw_a <= a;
		w_d <= d;
		w_s <= s;
		ta = 1'b0;
		tw = 1'b0;
		while (!(ta && tw)) begin
			@(negedge clk);
			na = aw_v && aw_rdy;
			nw = w_v && w_rdy;
			@(posedge clk);
			if (na) aw_v <= 1'b0;
			if (nw) w_v <= 1'b0;
			ta |= na;
			tw |= nw;
		end
		do @(negedge clk); while (!b_v);
		@(posedge clk);
	endtask

	task automatic axr(input logic [7:0] a, input logic [33:0] e);
		rq.push_back(e);
		ar_v <= 1'b1;
		ar_a <= a;
		do @(negedge clk); while (!ar_rdy);
		@(posedge clk);
		ar_v <= 1'b0;
		do @(negedge clk); while (!r_v);
		@(posedge clk);
	endtask

	task automatic mk(input int n, input logic [7:0] op, input logic pr);
		rnd = {$urandom, $urandom, $urandom, $urandom, $urandom};
		m = rnd[152:0];
		m.opts = op;
		m.plain_req = pr;
		m.plen = 16'(n);
		pl.delete();
		repeat (n) pl.push_back(8'($urandom));
	endtask

	// Expected frame worked out from the metadata and the local settings
	task automatic frame(input logic fmt);
		logic [7:0] b[$];
		logic [7:0] s;
		logic [15:0] len;
		len = m.plen + (fmt ? 16'h0012 : 16'h000C);
		b.push_back(fmt ? 8'h91 : 8'h90);
		for (int i = 7; i >= 0; i--) b.push_back(m.src64[i*8 +: 8]);
		b.push_back(m.src16[15:8]);
		b.push_back(m.src16[7:0]);
		if (fmt) begin
			b.push_back(m.plain_req ? lsep : m.src_ep);
			b.push_back(m.plain_req ? ldep : m.dst_ep);
			b.push_back(m.plain_req ? lclus[15:8] : m.cluster[15:8]);
			b.push_back(m.plain_req ? lclus[7:0] : m.cluster[7:0]);
			b.push_back(m.profile[15:8]);
			b.push_back(m.profile[7:0]);
		end
		b.push_back(m.opts);
		b = {b, pl};
		s = 8'h00;
		foreach (b[i]) s += b[i];
		sq = {sq, 8'h7E, len[15:8], len[7:0], b, 8'hFF - s};
	endtask

	task automatic send(input logic fmt);
		frame(fmt);
		nfr++;
		meta_v <= 1'b1;
		meta <= m;
		do @(negedge clk); while (!meta_rdy);
		@(posedge clk);
		meta_v <= 1'b0;
		foreach (pl[i]) begin
			pay_v <= 1'b1;
			pay_d <= pl[i];
			do @(negedge clk); while (!pay_rdy);
			@(posedge clk);
		end
		pay_v <= 1'b0;
	endtask

	task automatic drain();
		for (int k = 0; k < 3000 && sq.size() > 0; k++) @(posedge clk);
		repeat (2) @(posedge clk);
	endtask

	// ****
	// Tests
	// ****
	initial begin
		void'($urandom(32'hFE6E2994));
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		b_r <= 1'b1;
		r_r <= 1'b1;
		axr(8'h00, 34'h000000000);
		axr(8'h04, 34'h000000101);
		axr(8'h08, 34'h000000000);
		axr(8'h10, 34'h200000000);
		axw(8'h10, 32'h12345678, 4'hF, 2'h2);
		axw(8'h0C, 32'hFFFFFFFF, 4'hF, 2'h0);
		axr(8'h0C, 34'h000000000);
		axw(8'h04, 32'h0000A5C3, 4'h1, 2'h0);
		lsep = 8'hC3;
		axr(8'h04, 34'h0000001C3);
		$display("Test registers done");
		for (int i = 0; i < 9; i++) begin
			slow <= i[0];
			mk(i == 8 ? 0 : 1 + i % 5, opt_codes[i], i[1]);
			send(1'b0);
		end
		drain();
		$display("Test standard frames done");
		w = $urandom;
		axw(8'h04, w, 4'hF, 2'h0);
		lsep = w[7:0];
		ldep = w[15:8];
		w = $urandom;
		axw(8'h08, w, 4'hF, 2'h0);
		lclus = w[15:0];
		axw(8'h00, 32'h00000001, 4'hF, 2'h0);
		slow <= 1'b1;
		mk(6, 8'h02, 1'b0);
		m.src_ep = 8'hE0;
		m.dst_ep = 8'hE0;
		m.cluster = 16'h2211;
		m.profile = 16'hC105;
		send(1'b1);
		mk(4, 8'h61, 1'b1);
		send(1'b1);
		mk(3, 8'h22, 1'b0);
		send(1'b1);
		drain();
		axr(8'h0C, {2'h0, 16'(nfr), 16'h0000});
		chk("bytes left", 34'h000000000, 34'(sq.size()));
		$display("Test explicit frames done");
		stop_test();
	end
endmodule // tb_rx_packet_api_framer
